// File: src/adc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl #(
  parameter int AW = 11,
  parameter int DW = 8,
  parameter bit PAGE_MODE = 1'b1,
  parameter int PAGE_MAX_CYC = adc_pkg::ROW_LOW_PAGE_MAX_CYC,
  parameter int REFRESH_PERIOD_CYC = adc_pkg::REFRESH_PERIOD_CYC
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic [2*AW-1:0] req_addr_i,
  input wire logic [DW-1:0] req_wdata_i,
  output logic rd_valid_o,
  output logic [DW-1:0] rd_data_o,
  output logic row_strobe_n_o,
  output logic col_strobe_n_o,
  output logic write_en_n_o,
  output logic [AW-1:0] muxed_address_lines_o,
  output logic [DW-1:0] shared_data_lines_o,
  output logic shared_data_lines_oe_o,
  input wire logic [DW-1:0] shared_data_lines_i
);
  localparam int CW = adc_pkg::CNT_W;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ASET, ST_ROW, ST_COL, ST_CAS, ST_CHI, ST_RF_LEAD, ST_RF_ROW
  } adc_state_t;

  // ---------------------------------------------
  // Declarations
  // ---------------------------------------------
  adc_state_t state_ff, nxt_state;
  logic row_n_ff, nxt_row_n;
  logic col_n_ff, nxt_col_n;
  logic we_n_ff, nxt_we_n;
  logic [AW-1:0] addr_ff, nxt_addr;
  logic [DW-1:0] dq_ff, nxt_dq;
  logic oe_ff, nxt_oe;
  logic [CW-1:0] ras_cnt_ff, pre_cnt_ff, cas_cnt_ff, hi_cnt_ff;
  logic hold_ff, nxt_hold, ready_ff, take, consume;
  logic h_wr_ff, cur_wr_ff;
  logic [2*AW-1:0] h_addr_ff;
  logic [DW-1:0] h_wd_ff;
  logic [AW-1:0] open_row_ff;
  logic ref_pend_ff, ref_tick, ref_done;
  logic rd_got_ff, cap, rd_valid_ff;
  logic [DW-1:0] rd_data_ff;
  logic [DW-1:0] dq_s1_ff, dq_s2_ff, dq_s3_ff;
  logic rise_ok, page_hit, pre_ok;

  // Elapsed time at the next edge reaches n cycles
  function automatic logic met(input logic [CW-1:0] c, input int n);
    return (int'(c) + 1 >= n);
  endfunction

  wire logic [AW-1:0] h_row = h_addr_ff[2*AW-1:AW];
  wire logic [AW-1:0] h_col = h_addr_ff[AW-1:0];

  // ---------------------------------------------
  // Refresh scheduling
  // ---------------------------------------------
  adc_refresh_timer #(
    .INTERVAL(REFRESH_PERIOD_CYC / adc_pkg::REFRESH_ROWS)
  ) adc_refresh_timer_i (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .tick_o(ref_tick)
  );

  // A tick in the clearing cycle wins, so no refresh is lost
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ref_pend_ff <= 1'b0;
    end else if (ref_tick) begin
      ref_pend_ff <= 1'b1; // [R21]
    end else if (ref_done) begin
      ref_pend_ff <= 1'b0;
    end
  end

  // ---------------------------------------------
  // Request slot
  // ---------------------------------------------
  assign take = req_valid_i && ready_ff;
  assign nxt_hold = take ? 1'b1 : (consume ? 1'b0 : hold_ff);

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      hold_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else begin
      hold_ff <= nxt_hold;
      ready_ff <= !nxt_hold;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      h_wr_ff <= 1'b0;
      h_addr_ff <= '0;
      h_wd_ff <= '0;
    end else if (take) begin
      h_wr_ff <= req_write_i;
      h_addr_ff <= req_addr_i;
      h_wd_ff <= req_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cur_wr_ff <= 1'b1;
      open_row_ff <= '0;
    end else begin
      if (consume) begin
        cur_wr_ff <= h_wr_ff;
      end
      if (state_ff == ST_ASET) begin
        open_row_ff <= h_row;
      end
    end
  end

  // ---------------------------------------------
  // Interval counters
  // ---------------------------------------------
  // Counters saturate so a long idle never wraps into a short gap
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ras_cnt_ff <= '1;
      pre_cnt_ff <= '1;
      cas_cnt_ff <= '1;
      hi_cnt_ff <= '1;
    end else begin
      if (row_n_ff && !nxt_row_n) begin
        ras_cnt_ff <= '0;
      end else if (ras_cnt_ff != '1) begin
        ras_cnt_ff <= ras_cnt_ff + 1'b1;
      end
      if (!row_n_ff && nxt_row_n) begin
        pre_cnt_ff <= '0;
      end else if (pre_cnt_ff != '1) begin
        pre_cnt_ff <= pre_cnt_ff + 1'b1;
      end
      if (col_n_ff && !nxt_col_n) begin
        cas_cnt_ff <= '0;
      end else if (cas_cnt_ff != '1) begin
        cas_cnt_ff <= cas_cnt_ff + 1'b1;
      end
      if (!col_n_ff && nxt_col_n) begin
        hi_cnt_ff <= '0;
      end else if (hi_cnt_ff != '1) begin
        hi_cnt_ff <= hi_cnt_ff + 1'b1;
      end
    end
  end

  // ---------------------------------------------
  // Read capture
  // ---------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
      dq_s3_ff <= '0;
    end else begin
      dq_s1_ff <= shared_data_lines_i;
      dq_s2_ff <= dq_s1_ff;
      dq_s3_ff <= dq_s2_ff;
    end
  end

  // Wait out access time plus synchroniser depth before sampling
  assign cap = (state_ff == ST_CAS) && !cur_wr_ff && !rd_got_ff
    && (int'(ras_cnt_ff) >= adc_pkg::ROW_ACCESS_TIME_CYC + adc_pkg::SYNC_STAGES) // [R22]
    && (int'(cas_cnt_ff) >= adc_pkg::COL_ACCESS_TIME_CYC + adc_pkg::SYNC_STAGES)
    && (dq_s2_ff == dq_s3_ff);

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      rd_got_ff <= 1'b0;
      rd_valid_ff <= 1'b0;
      rd_data_ff <= '0;
    end else begin
      rd_valid_ff <= cap;
      if (cap) begin
        rd_got_ff <= 1'b1;
        rd_data_ff <= dq_s3_ff;
      end else if (consume) begin
        rd_got_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------
  // Sequencer
  // ---------------------------------------------
  assign pre_ok = met(pre_cnt_ff, adc_pkg::ROW_PRECHARGE_MIN_CYC) // [R7]
    && met(ras_cnt_ff, adc_pkg::RANDOM_CYCLE_MIN_CYC) // [R2]
    && met(hi_cnt_ff, adc_pkg::COLUMN_HIGH_PULSE_CYC);

  assign rise_ok = met(cas_cnt_ff, adc_pkg::COLUMN_LOW_PULSE_CYC) // [R10]
    && met(ras_cnt_ff, adc_pkg::ROW_TO_COLUMN_RISE_CYC) // [R18]
    && met(cas_cnt_ff, adc_pkg::COLUMN_TO_ROW_RISE_CYC) // [R18]
    && met(ras_cnt_ff, adc_pkg::ROW_LOW_NONPAGE_CYC) // [R8]
    && (cur_wr_ff ? (met(cas_cnt_ff, adc_pkg::WRITE_WE_HOLD_CYC) // [R13]
      && met(cas_cnt_ff, adc_pkg::WRITE_DATA_HOLD_CYC)) : rd_got_ff); // [R14]

  // Page kept open only while far from the longest low time
  assign page_hit = PAGE_MODE && hold_ff && (h_row == open_row_ff) && !ref_pend_ff
    && (int'(ras_cnt_ff) < PAGE_MAX_CYC - adc_pkg::PAGE_GUARD_CYC); // [R9]

  always_comb begin
    nxt_state = state_ff;
    nxt_row_n = row_n_ff;
    nxt_col_n = col_n_ff;
    nxt_we_n = we_n_ff;
    nxt_addr = addr_ff;
    nxt_dq = dq_ff;
    nxt_oe = oe_ff;
    consume = 1'b0;
    ref_done = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (ref_pend_ff && pre_ok) begin
          nxt_col_n = 1'b0; // [R4]
          nxt_state = ST_RF_LEAD;
        end else if (hold_ff && pre_ok) begin
          nxt_addr = h_row; // [R15]
          nxt_state = ST_ASET;
        end
      end
      ST_ASET: begin
        nxt_row_n = 1'b0;
        nxt_state = ST_ROW;
      end
      ST_ROW: begin
        if (met(ras_cnt_ff, adc_pkg::ROW_ADDR_HOLD_CYC) // [R15]
            && met(ras_cnt_ff, adc_pkg::ROW_TO_COLADDR_MIN_CYC)) begin // [R16]
          nxt_addr = h_col;
          nxt_we_n = !h_wr_ff; // [R12] [R20]
          nxt_oe = h_wr_ff;
          nxt_dq = h_wd_ff; // [R14]
          consume = 1'b1;
          nxt_state = ST_COL;
        end
      end
      ST_COL: begin
        if (met(ras_cnt_ff, adc_pkg::ROW_TO_COLUMN_DELAY_CYC) // [R17]
            && met(cas_cnt_ff, adc_pkg::PAGE_CYCLE_MIN_CYC)) begin // [R3]
          nxt_col_n = 1'b0;
          nxt_state = ST_CAS;
        end
      end
      ST_CAS: begin
        if (rise_ok) begin
          nxt_col_n = 1'b1;
          nxt_we_n = 1'b1; // [R11]
          nxt_oe = 1'b0;
          if (page_hit) begin
            nxt_state = ST_CHI;
          end else begin
            // Column address is already three cycles old here
            nxt_row_n = 1'b1; // [R19]
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_CHI: begin
        if (met(hi_cnt_ff, adc_pkg::COLUMN_HIGH_PULSE_CYC) // [R10]
            && (!h_wr_ff || cur_wr_ff
              || met(hi_cnt_ff, adc_pkg::OUTPUT_RELEASE_DELAY_CYC))) begin // [R1]
          nxt_addr = h_col;
          nxt_we_n = !h_wr_ff; // [R12]
          nxt_oe = h_wr_ff;
          nxt_dq = h_wd_ff;
          consume = 1'b1;
          nxt_state = ST_COL;
        end
      end
      ST_RF_LEAD: begin
        // Write enable has been high since the last column rise
        if (met(cas_cnt_ff, adc_pkg::REFRESH_COLUMN_LEAD_CYC)) begin // [R4] [R6]
          nxt_row_n = 1'b0;
          nxt_state = ST_RF_ROW;
        end
      end
      ST_RF_ROW: begin
        if (met(ras_cnt_ff, adc_pkg::ROW_LOW_NONPAGE_CYC) // [R8]
            && met(ras_cnt_ff, adc_pkg::REFRESH_COLUMN_HOLD_CYC) // [R5]
            && met(ras_cnt_ff, adc_pkg::REFRESH_WE_HOLD_CYC) // [R6]
            && met(cas_cnt_ff, adc_pkg::COLUMN_LOW_PULSE_CYC)) begin
          nxt_row_n = 1'b1;
          nxt_col_n = 1'b1;
          ref_done = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_row_n = 1'b1;
        nxt_col_n = 1'b1;
        nxt_we_n = 1'b1;
        nxt_oe = 1'b0;
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------
  // Pin registers
  // ---------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      row_n_ff <= 1'b1;
      col_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      addr_ff <= '0;
      dq_ff <= '0;
      oe_ff <= 1'b0;
    end else begin
      row_n_ff <= nxt_row_n;
      col_n_ff <= nxt_col_n;
      we_n_ff <= nxt_we_n;
      addr_ff <= nxt_addr;
      dq_ff <= nxt_dq;
      oe_ff <= nxt_oe;
    end
  end

  assign req_ready_o = ready_ff;
  assign rd_valid_o = rd_valid_ff;
  assign rd_data_o = rd_data_ff;
  assign row_strobe_n_o = row_n_ff;
  assign col_strobe_n_o = col_n_ff;
  assign write_en_n_o = we_n_ff;
  assign muxed_address_lines_o = addr_ff;
  assign shared_data_lines_o = dq_ff;
  assign shared_data_lines_oe_o = oe_ff;

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_cbr_start;
    $fell(row_n_ff) && !col_n_ff;
  endsequence

  sequence s_acc_start;
    $fell(row_n_ff) && col_n_ff;
  endsequence

  property p_precharge;
    $rose(row_n_ff) |-> row_n_ff [*4];
  endproperty
  a_precharge: assert property (p_precharge) else $error("precharge short"); // [R7]

  property p_random_cycle;
    $fell(row_n_ff) |-> int'($past(ras_cnt_ff)) + 1 >= adc_pkg::RANDOM_CYCLE_MIN_CYC;
  endproperty
  a_random_cycle: assert property (p_random_cycle) else $error("cycle short"); // [R2]

  property p_row_low;
    $fell(row_n_ff) |-> !row_n_ff [*6];
  endproperty
  a_row_low: assert property (p_row_low) else $error("row low short"); // [R8]

  property p_col_low;
    $fell(col_n_ff) |-> !col_n_ff [*2];
  endproperty
  a_col_low: assert property (p_col_low) else $error("column low short"); // [R10]

  property p_cbr;
    s_cbr_start |-> $past(!col_n_ff) && $past(we_n_ff) ##0 (!col_n_ff && we_n_ff) [*2];
  endproperty
  a_cbr: assert property (p_cbr) else $error("refresh order broken"); // [R4]

  property p_row_addr;
    s_acc_start |=> $stable(addr_ff) ##1 col_n_ff;
  endproperty
  a_row_addr: assert property (p_row_addr) else $error("row address hold"); // [R15]

  property p_early_write;
    $fell(col_n_ff) && !we_n_ff |-> $past(!we_n_ff) && $past(oe_ff)
      ##1 (!we_n_ff && oe_ff && $stable(dq_ff));
  endproperty
  a_early_write: assert property (p_early_write) else $error("late write"); // [R12]

  property p_read_we;
    $fell(col_n_ff) && we_n_ff && !row_n_ff |-> we_n_ff [*2];
  endproperty
  a_read_we: assert property (p_read_we) else $error("read we dropped"); // [R11]

  // Only a read leaves the far side driving; write to write may reload at once
  property p_release;
    $rose(col_n_ff) && $past(we_n_ff) && !row_n_ff |-> !oe_ff [*2];
  endproperty
  a_release: assert property (p_release) else $error("bus driven early"); // [R1]

  property p_col_delay;
    s_acc_start |-> col_n_ff [*2];
  endproperty
  a_col_delay: assert property (p_col_delay) else $error("column too early"); // [R17]
endmodule
`default_nettype wire

// File: src/adc_pkg.sv
// Functional notes
// R1 - Module releases shared data lines within 15 ns after column strobe rises.
// R2 - Row strobe falls are spaced at least 110 ns apart.
// R3 - Page-mode column strobe cycles are spaced at least 40 ns apart.
// R4 - Refresh: column strobe falls at least 10 ns before row strobe falls.
// R5 - Refresh: column strobe stays low 15 ns after row strobe falls.
// R6 - Refresh: write enable high from 10 ns before to 10 ns after row fall.
// R7 - Row strobe stays high at least 40 ns of precharge between accesses.
// R8 - Non-page row strobe low lasts 60 ns to 10 000 ns.
// R9 - Page-mode row strobe low period ends within 100 000 ns.
// R10 - Column strobe low 15 ns to 10 000 ns; high at least 10 ns.
// R11 - Read: write enable high by column fall, held until a strobe rises.
// R12 - Write: write enable low no later than column strobe fall.
// R13 - Write: write enable held low at least 15 ns after column fall.
// R14 - Write data valid by column fall and held 10 ns afterwards.
// R15 - Row address valid at row fall and held 10 ns after it.
// R16 - Column address switched 15 ns to 30 ns after row strobe falls.
// R17 - Column strobe falls 20 ns or more after row strobe falls.
// R18 - Row rises 15 ns after column fall; column low until 60 ns after row fall.
// R19 - Column address presented at least 30 ns before row strobe rises.
// R20 - Every write is an early write because data lines are shared.
// R21 - Issue 1024 refresh cycles within every 16 ms.
// R22 - Read data valid no later than 60 ns after row strobe falls.
// R23 - Minimum times round up to cycles, maximum times round down.
package adc_pkg;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int SYNC_STAGES = 3;
  localparam int CNT_W = 17;
  localparam int PAGE_GUARD_CYC = 32;

  // ---------------------------------------------
  // Conversion
  // ---------------------------------------------
  function automatic int min_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS; // [R23]
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max_cyc(input int ns);
    int c;
    c = (ns * 1000) / CLK_PERIOD_PS; // [R23]
    return (c < 1) ? 1 : c;
  endfunction

  // ---------------------------------------------
  // Timing
  // ---------------------------------------------
  localparam int OUTPUT_RELEASE_DELAY_NS = 15;
  localparam int OUTPUT_RELEASE_DELAY_CYC = min_cyc(OUTPUT_RELEASE_DELAY_NS);
  localparam int RANDOM_CYCLE_MIN_NS = 110;
  localparam int RANDOM_CYCLE_MIN_CYC = min_cyc(RANDOM_CYCLE_MIN_NS);
  localparam int PAGE_CYCLE_MIN_NS = 40;
  localparam int PAGE_CYCLE_MIN_CYC = min_cyc(PAGE_CYCLE_MIN_NS);
  localparam int REFRESH_COLUMN_LEAD_NS = 10;
  localparam int REFRESH_COLUMN_LEAD_CYC = min_cyc(REFRESH_COLUMN_LEAD_NS);
  localparam int REFRESH_COLUMN_HOLD_NS = 15;
  localparam int REFRESH_COLUMN_HOLD_CYC = min_cyc(REFRESH_COLUMN_HOLD_NS);
  localparam int REFRESH_WE_HOLD_NS = 10;
  localparam int REFRESH_WE_HOLD_CYC = min_cyc(REFRESH_WE_HOLD_NS);
  localparam int ROW_PRECHARGE_MIN_NS = 40;
  localparam int ROW_PRECHARGE_MIN_CYC = min_cyc(ROW_PRECHARGE_MIN_NS);
  localparam int ROW_LOW_NONPAGE_NS = 60;
  localparam int ROW_LOW_NONPAGE_CYC = min_cyc(ROW_LOW_NONPAGE_NS);
  localparam int ROW_LOW_PAGE_MAX_NS = 100000;
  localparam int ROW_LOW_PAGE_MAX_CYC = max_cyc(ROW_LOW_PAGE_MAX_NS);
  localparam int COLUMN_LOW_PULSE_NS = 15;
  localparam int COLUMN_LOW_PULSE_CYC = min_cyc(COLUMN_LOW_PULSE_NS);
  localparam int COLUMN_HIGH_PULSE_NS = 10;
  localparam int COLUMN_HIGH_PULSE_CYC = min_cyc(COLUMN_HIGH_PULSE_NS);
  localparam int WRITE_WE_HOLD_NS = 15;
  localparam int WRITE_WE_HOLD_CYC = min_cyc(WRITE_WE_HOLD_NS);
  localparam int WRITE_DATA_HOLD_NS = 10;
  localparam int WRITE_DATA_HOLD_CYC = min_cyc(WRITE_DATA_HOLD_NS);
  localparam int ROW_ADDR_HOLD_NS = 10;
  localparam int ROW_ADDR_HOLD_CYC = min_cyc(ROW_ADDR_HOLD_NS);
  localparam int ROW_TO_COLADDR_MIN_NS = 15;
  localparam int ROW_TO_COLADDR_MIN_CYC = min_cyc(ROW_TO_COLADDR_MIN_NS);
  localparam int ROW_TO_COLUMN_DELAY_NS = 20;
  localparam int ROW_TO_COLUMN_DELAY_CYC = min_cyc(ROW_TO_COLUMN_DELAY_NS);
  localparam int COLUMN_TO_ROW_RISE_NS = 15;
  localparam int COLUMN_TO_ROW_RISE_CYC = min_cyc(COLUMN_TO_ROW_RISE_NS);
  localparam int ROW_TO_COLUMN_RISE_NS = 60;
  localparam int ROW_TO_COLUMN_RISE_CYC = min_cyc(ROW_TO_COLUMN_RISE_NS);
  localparam int ROW_ACCESS_TIME_NS = 60;
  localparam int ROW_ACCESS_TIME_CYC = max_cyc(ROW_ACCESS_TIME_NS);
  localparam int COL_ACCESS_TIME_NS = 15;
  localparam int COL_ACCESS_TIME_CYC = max_cyc(COL_ACCESS_TIME_NS);
  localparam int REFRESH_PERIOD_MS = 16;
  localparam int REFRESH_ROWS = 1024;
  localparam int REFRESH_PERIOD_CYC = REFRESH_PERIOD_MS * (1000000000 / CLK_PERIOD_PS);
endpackage

// File: src/adc_refresh_timer.sv
`timescale 1ns/10ps
`default_nettype none
module adc_refresh_timer #(
  parameter int INTERVAL = 1562
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  output logic tick_o
);
  localparam int CW = $clog2(INTERVAL + 1);

  logic [CW-1:0] cnt_ff;
  logic tick_ff;

  // Interval rounded down so that late service still fits the period
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (cnt_ff == CW'(INTERVAL - 1)) begin
      cnt_ff <= '0;
      tick_ff <= 1'b1; // [R21]
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  assign tick_o = tick_ff;
endmodule
`default_nettype wire

// File: verif/adc_dram_model.sv
`timescale 1ns/10ps
`default_nettype none
module adc_dram_model #(
  parameter real ACCESS_NS = 15.0,
  parameter real RELEASE_NS = 5.0
) (
  input wire logic row_strobe_n_i,
  input wire logic col_strobe_n_i,
  input wire logic write_en_n_i,
  input wire logic [10:0] addr_i,
  input wire logic [7:0] dq_i,
  input wire logic dq_oe_i,
  output logic [7:0] dq_o,
  output logic [15:0] viol_o,
  output logic [15:0] refreshes_o,
  output logic [15:0] rows_o,
  output logic [15:0] cols_o
);
  logic [7:0] mem [logic [21:0]];
  logic [10:0] row = 11'h000;
  logic [7:0] drv_data = 8'h00;
  logic [7:0] last = 8'h00;
  logic drv = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic refr = 1'b0;
  realtime trf = -1.0e6;
  realtime trr = -1.0e6;
  realtime tcf = -1.0e6;
  realtime tcr = -1.0e6;
  realtime twe = -1.0e6;
  realtime tac = -1.0e6;

  initial begin
    viol_o = 16'h0000;
    refreshes_o = 16'h0000;
    rows_o = 16'h0000;
    cols_o = 16'h0000;
  end

  task automatic bad();
    viol_o++;
  endtask

  // ----------------------------------------
  // Data lines
  // ----------------------------------------
  // Released lines show the inverse, so a late capture cannot pass by luck
  assign dq_o = dq_oe_i ? dq_i : (drv ? drv_data : ~last);
  always @(negedge drv) last = drv_data;
  always @(negedge dq_oe_i) last = dq_i;
  always @(posedge drv) if (dq_oe_i) bad();
  always @(posedge dq_oe_i) if (drv) bad();
  always @(dq_i or dq_oe_i) if (wr && $realtime - tcf < 10.0) bad();

  // ----------------------------------------
  // Strobe timing
  // ----------------------------------------
  always @(negedge row_strobe_n_i) begin
    if ($realtime - trf < 110.0 || $realtime - trr < 40.0) bad();
    refr = !col_strobe_n_i;
    if (refr) begin
      refreshes_o++;
      if ($realtime - tcf < 10.0 || !write_en_n_i || $realtime - twe < 10.0) bad();
    end else begin
      rows_o++;
      row = addr_i;
    end
    trf = $realtime;
  end

  always @(posedge row_strobe_n_i) if (trf >= 0.0) begin
    if ($realtime - trf < 60.0 || $realtime - trf > 100000.0) bad();
    if (!refr && ($realtime - tcf < 15.0 || $realtime - tac < 30.0)) bad();
    trr = $realtime;
  end

  always @(negedge col_strobe_n_i) begin
    if ($realtime - tcr < 10.0) bad();
    rd = 1'b0;
    wr = 1'b0;
    if (!row_strobe_n_i) begin
      if ($realtime - trf < 20.0 || $realtime - tcf < 40.0) bad();
      cols_o++;
      if (!write_en_n_i) begin
        wr = 1'b1;
        if (!dq_oe_i) bad();
        mem[{row, addr_i}] = dq_i;
      end else begin
        rd = 1'b1;
        drv_data = mem.exists({row, addr_i}) ? mem[{row, addr_i}] : ~addr_i[7:0];
        drv <= #(ACCESS_NS) 1'b1;
      end
    end
    tcf = $realtime;
  end

  always @(posedge col_strobe_n_i) if (tcf >= 0.0) begin
    if ($realtime - tcf < 15.0 || $realtime - tcf > 10000.0) bad();
    if ($realtime - trf < (refr ? 15.0 : 60.0)) bad();
    if (rd) drv <= #(RELEASE_NS) 1'b0;
    rd = 1'b0;
    tcr = $realtime;
  end

  always @(write_en_n_i) begin
    if (!col_strobe_n_i && !row_strobe_n_i && (rd || $realtime - tcf < 15.0)) bad();
    if (refr && !row_strobe_n_i && $realtime - trf < 10.0) bad();
    twe = $realtime;
  end

  always @(addr_i) begin
    if (!row_strobe_n_i && $realtime - trf < 15.0) bad();
    tac = $realtime;
  end
endmodule
`default_nettype wire

// File: verif/async_dram_module_access_timing_bench.sv
`timescale 1ns/10ps
`default_nettype none
module async_dram_module_access_timing_bench;
  localparam int INTERVAL = 40;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic req_write_i = 1'b0;
  logic [21:0] req_addr_i = 22'h000000;
  logic [7:0] req_wdata_i = 8'h00;
  logic req_ready_o, rd_valid_o, row_strobe_n, col_strobe_n, write_en_n, data_oe;
  logic [7:0] rd_data_o, data_out, data_in;
  logic [10:0] addr;
  logic [15:0] viol, refs, rows, cols;
  logic [7:0] got_q[$];
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 core_clk_i = ~core_clk_i;

  // Short refresh interval keeps the run small
  adc_ctrl #(.PAGE_MAX_CYC(64), .REFRESH_PERIOD_CYC(INTERVAL * 1024)) adc_ctrl_i (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .row_strobe_n_o(row_strobe_n), .col_strobe_n_o(col_strobe_n),
    .write_en_n_o(write_en_n), .muxed_address_lines_o(addr),
    .shared_data_lines_o(data_out), .shared_data_lines_oe_o(data_oe),
    .shared_data_lines_i(data_in));

  adc_dram_model adc_dram_model_i (
    .row_strobe_n_i(row_strobe_n), .col_strobe_n_i(col_strobe_n),
    .write_en_n_i(write_en_n), .addr_i(addr), .dq_i(data_out), .dq_oe_i(data_oe),
    .dq_o(data_in), .viol_o(viol), .refreshes_o(refs), .rows_o(rows), .cols_o(cols));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  // Read pulses are queued so pipelined reads lose nothing
  always @(posedge core_clk_i) begin
    #1;
    if (rd_valid_o === 1'b1) got_q.push_back(rd_data_o);
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Valid stays up after the take so a follow-on request is already held
  task automatic req(input logic wr, input logic [21:0] a, input logic [7:0] d);
    int n;
    req_valid_i = 1'b1;
    req_write_i = wr;
    req_addr_i = a;
    req_wdata_i = d;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 300) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    check(16'(n < 300), 16'h0001);
    @(posedge core_clk_i);
    #1;
    if (!wr) exp_q.push_back(d);
  endtask

  task automatic drain();
    int n;
    req_valid_i = 1'b0;
    n = 0;
    while (got_q.size() < exp_q.size() && n < 500) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    check(16'(got_q.size()), 16'(exp_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0) check(got_q.pop_front(), exp_q.pop_front());
    repeat (20) @(posedge core_clk_i);
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_random();
    logic [15:0] r0;
    r0 = rows;
    req(1'b1, {11'h005, 11'h003}, 8'ha5);
    req(1'b1, {11'h7ff, 11'h7ff}, 8'h5a);
    req(1'b0, {11'h005, 11'h003}, 8'ha5);
    req(1'b0, {11'h7ff, 11'h7ff}, 8'h5a);
    req(1'b0, {11'h000, 11'h0c3}, 8'h3c);
    drain();
    check(rows - r0, 16'd5);
    check(viol, 16'h0000);
  endtask

  task automatic s_page();
    logic [15:0] r0;
    logic [15:0] c0;
    r0 = rows;
    c0 = cols;
    for (int i = 0; i < 4; i++) req(1'b1, {11'h123, 11'(i)}, 8'(8'h90 + i));
    for (int i = 0; i < 4; i++) req(1'b0, {11'h123, 11'(i)}, 8'(8'h90 + i));
    drain();
    check(cols - c0, 16'd8);
    check(16'((rows - r0) < 16'd8), 16'h0001);
    check(viol, 16'h0000);
  endtask

  task automatic s_refresh();
    logic [15:0] f0;
    f0 = refs;
    repeat (INTERVAL * 20) @(posedge core_clk_i);
    #1;
    check(16'((refs - f0) >= 16'd19 && (refs - f0) <= 16'd21), 16'h0001);
    check(viol, 16'h0000);
  endtask

  initial begin
    repeat (5) @(posedge core_clk_i);
    #1;
    check({11'h000, row_strobe_n, col_strobe_n, write_en_n, data_oe, req_ready_o}, 16'h001c);
    resetn_i = 1'b1;
    s_random();
    s_page();
    s_refresh();
    stop_test();
  end
endmodule
`default_nettype wire
